/* verilog/param_page_engine.sv */
// Parameter page program and erase engine of a serial flash, SPI slave side.
// Assumes SPI pins are asynchronous to sys_clk and much slower (sck >= 8 clocks).
//
// Summary of operation
// - Page program accepted only while the write enable latch is set.
// - Only the low address byte selects the page byte; upper bits ignored.
// - Unsent bytes stay unchanged; bytes past 256 wrap to page start.
// - Program starts only if chip select rises on a byte boundary.
// - Program cycle is self-timed; status reads still work during it.
// - Write in progress is 1 during the cycle, 0 when done.
// - Write enable latch clears once a program or erase cycle starts.
// - Program refused when block protect bits protect the page.
// - Opcode D5h erases the page, all 256 bytes to FFh.
// - Erase accepted only while the write enable latch is set.
// - Erase starts only if chip select rises right after the opcode.
// - Erase shows write in progress, serves status reads, clears on end.
// - Erase refused whenever any block protect bit is nonzero.
// - All instructions ignored until 10 ms after supply becomes valid.
// - Power-up enters standby with the write enable latch reset.
// - Delivered page reads FFh and status reads 00h.
// - Below minimum supply all operations stop, no instruction answered.
// - Erase cycle lasts typically 20 ms, at most 100 ms.
`timescale 1ns/1ps
module param_page_engine #(
	parameter int unsigned LOCKOUT_CYCLES = param_page_pkg::LOCKOUT_CYCLES,
	parameter int unsigned PROGRAM_CYCLES = param_page_pkg::PROGRAM_CYCLES,
	parameter int unsigned ERASE_CYCLES   = param_page_pkg::ERASE_CYCLES
) (
	input  wire logic       sys_clk,
	input  wire logic       rst,
	input  wire logic       spi_cs_n,
	input  wire logic       spi_sck,
	input  wire logic       spi_si,
	input  wire logic       supply_ok,
	input  wire logic [2:0] block_protect,
	input  wire logic [7:0] page_rd_addr,
	output logic      [7:0] page_rd_data,
	output logic            spi_so,
	output logic            spi_so_oe,
	output logic            write_in_progress,
	output logic            write_enable_latch,
	output logic            device_ready
);
	// ****************************************
	// Input synchronisers and edges
	// ****************************************
	logic [3:0] sync1_reg, sync2_reg;
	logic       sck_prev_reg, cs_prev_reg;
	logic       sck_s, cs_s, si_s, supply_s;
	logic       sck_rise, sck_fall, cs_rise, selected;

	// Two flops per pin; only the second stage is read
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			sync1_reg <= 4'h1;
			sync2_reg <= 4'h1;
		end else begin
			sync1_reg <= {supply_ok, spi_si, spi_sck, spi_cs_n};
			sync2_reg <= sync1_reg;
		end
	end
	assign {supply_s, si_s, sck_s, cs_s} = sync2_reg;

	// Edge history of the synchronised clock and select
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			sck_prev_reg <= 1'b0;
			cs_prev_reg  <= 1'b1;
		end else begin
			sck_prev_reg <= sck_s;
			cs_prev_reg  <= cs_s;
		end
	end
	assign sck_rise = sck_s & ~sck_prev_reg;
	assign sck_fall = ~sck_s & sck_prev_reg;
	assign cs_rise  = cs_s & ~cs_prev_reg;
	assign selected = ~cs_s;

	// ****************************************
	// Power-up lockout
	// ****************************************
	logic [31:0] lock_cnt_reg;
	logic        ready_reg;

	// Counter restarts whenever the supply drops below its minimum
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			lock_cnt_reg <= 32'h0;
			ready_reg    <= 1'b0;
		end else if (!supply_s) begin
			lock_cnt_reg <= 32'h0;
			ready_reg    <= 1'b0;
		end else if (!ready_reg) begin
			lock_cnt_reg <= lock_cnt_reg + 32'h1;
			if (lock_cnt_reg == 32'(LOCKOUT_CYCLES - 1)) begin
				ready_reg <= 1'b1;
			end
		end
	end
	assign device_ready = ready_reg;

	// ****************************************
	// Cycle engine declarations
	// ****************************************
	param_page_pkg::cycle_state_t state_reg;
	param_page_pkg::cycle_mode_t  mode_reg, pend_mode_reg;
	logic        pend_reg, busy, wel_reg, bp_clear;
	logic [8:0]  walk_cnt_reg;
	logic [31:0] cyc_cnt_reg, cyc_target;

	assign busy     = pend_reg | (state_reg != param_page_pkg::ST_IDLE);
	assign bp_clear = (block_protect == 3'h0);

	// ****************************************
	// Serial receiver
	// ****************************************
	logic [2:0] bit_cnt_reg, byte_cnt_reg;
	logic [6:0] shift_reg;
	logic [7:0] opcode_reg, addr_reg, rx_byte;
	logic       any_data_reg, frame_bad_reg, byte_done, push, buf_in_ready;

	assign rx_byte   = {shift_reg, si_s};
	assign byte_done = selected & sck_rise & (bit_cnt_reg == 3'h7);
	// Data bytes pass only for an allowed program frame
	assign push = byte_done & byte_cnt_reg[2] & ready_reg & ~busy & wel_reg & bp_clear
		& (opcode_reg == param_page_pkg::OP_PAGE_PROGRAM);

	// Bit and byte counting; a deselect restarts the frame
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			bit_cnt_reg  <= 3'h0;
			byte_cnt_reg <= 3'h0;
			shift_reg    <= 7'h0;
		end else if (cs_s) begin
			bit_cnt_reg  <= 3'h0;
			byte_cnt_reg <= 3'h0;
		end else if (sck_rise) begin
			shift_reg   <= rx_byte[6:0];
			bit_cnt_reg <= bit_cnt_reg + 3'h1;
			if (byte_done && byte_cnt_reg != param_page_pkg::BYTES_SAT) begin
				byte_cnt_reg <= byte_cnt_reg + 3'h1;
			end
		end
	end

	// Opcode and page byte address capture
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			opcode_reg <= 8'h0;
			addr_reg   <= 8'h0;
		end else if (byte_done) begin
			if (byte_cnt_reg == 3'h0) begin
				opcode_reg <= rx_byte;
			end else if (byte_cnt_reg == 3'h3) begin
				addr_reg <= rx_byte;  // Upper two address bytes dropped
			end else if (byte_cnt_reg[2]) begin
				addr_reg <= addr_reg + 8'h1;  // Wraps within the page
			end
		end
	end

	// Frame bookkeeping; an overrun spoils the whole frame
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			any_data_reg  <= 1'b0;
			frame_bad_reg <= 1'b0;
		end else if (cs_s) begin
			any_data_reg  <= 1'b0;
			frame_bad_reg <= 1'b0;
		end else if (push) begin
			any_data_reg <= 1'b1;
			if (!buf_in_ready) begin
				frame_bad_reg <= 1'b1;
			end
		end
	end

	// ****************************************
	// Two-entry data buffer
	// ****************************************
	logic [15:0] buf_mem_reg [0:1];
	logic        buf_wp_reg, buf_rp_reg, buf_out_valid, buf_out_ready;
	logic [1:0]  buf_cnt_reg;
	logic [15:0] buf_head;

	assign buf_in_ready  = (buf_cnt_reg != 2'h2);
	assign buf_out_valid = (buf_cnt_reg != 2'h0);
	// Staging store is only written by the buffer while no walk runs
	assign buf_out_ready = (state_reg == param_page_pkg::ST_IDLE);
	assign buf_head      = buf_mem_reg[buf_rp_reg];

	// Pointers and occupancy
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			buf_wp_reg  <= 1'b0;
			buf_rp_reg  <= 1'b0;
			buf_cnt_reg <= 2'h0;
		end else begin
			if (push && buf_in_ready) begin
				buf_wp_reg <= ~buf_wp_reg;
			end
			if (buf_out_valid && buf_out_ready) begin
				buf_rp_reg <= ~buf_rp_reg;
			end
			buf_cnt_reg <= buf_cnt_reg + 2'(push && buf_in_ready)
				- 2'(buf_out_valid && buf_out_ready);
		end
	end

	// Entry storage, address beside data
	always_ff @(posedge sys_clk) begin
		if (push && buf_in_ready) begin
			buf_mem_reg[buf_wp_reg] <= {addr_reg, rx_byte};
		end
	end

	// ****************************************
	// Commit decisions at deselect
	// ****************************************
	logic whole, go_erase, go_prog, go_scrub, go_write_enable_cmd;

	assign whole    = (bit_cnt_reg == 3'h0);
	assign go_write_enable_cmd  = cs_rise & ready_reg & ~busy & whole & (byte_cnt_reg == 3'h1)
		& (opcode_reg == param_page_pkg::OP_WRITE_ENABLE);
	// Erase only for exactly one opcode byte
	assign go_erase = cs_rise & ready_reg & ~busy & whole & (byte_cnt_reg == 3'h1)
		& wel_reg & bp_clear & (opcode_reg == param_page_pkg::OP_PAGE_ERASE);
	// Program needs a clean byte boundary, otherwise it is discarded
	assign go_prog  = cs_rise & any_data_reg & whole & ~frame_bad_reg;
	assign go_scrub = cs_rise & any_data_reg & ~go_prog;

	// Write enable latch; cleared at power-up and when a program or erase cycle launches, not a scrub
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			wel_reg <= 1'b0;
		end else if (!ready_reg) begin
			wel_reg <= 1'b0;
		end else if (go_erase || go_prog) begin
			wel_reg <= 1'b0;
		end else if (go_write_enable_cmd) begin
			wel_reg <= 1'b1;
		end
	end
	assign write_enable_latch = wel_reg;

	// ****************************************
	// Cycle engine
	// ****************************************
	logic [7:0] page_q, stage_q, page_wdata, walk_addr, wr_addr;
	logic       walking, page_we, stage_we;

	assign cyc_target = (mode_reg == param_page_pkg::MODE_ERASE) ? 32'(ERASE_CYCLES)
		: 32'(PROGRAM_CYCLES);
	assign walking    = (state_reg == param_page_pkg::ST_WALK);
	assign walk_addr  = walk_cnt_reg[7:0];
	assign wr_addr    = walk_addr - 8'h1;

	// Pending start waits for the buffer to drain its last byte
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			pend_reg      <= 1'b0;
			pend_mode_reg <= param_page_pkg::MODE_SCRUB;
		end else if (!ready_reg) begin
			pend_reg <= 1'b0;
		end else if (go_erase || go_prog || go_scrub) begin
			pend_reg      <= 1'b1;
			pend_mode_reg <= go_erase ? param_page_pkg::MODE_ERASE
				: (go_prog ? param_page_pkg::MODE_PROG : param_page_pkg::MODE_SCRUB);
		end else if (state_reg == param_page_pkg::ST_IDLE && !buf_out_valid) begin
			pend_reg <= 1'b0;
		end
	end

	// Walk every page word, then hold busy for the self-timed remainder, except after a scrub walk
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			state_reg    <= param_page_pkg::ST_IDLE;
			mode_reg     <= param_page_pkg::MODE_SCRUB;
			walk_cnt_reg <= 9'h0;
			cyc_cnt_reg  <= 32'h0;
		end else if (!ready_reg) begin  // Supply loss abandons the cycle
			state_reg <= param_page_pkg::ST_IDLE;
		end else begin
			cyc_cnt_reg <= cyc_cnt_reg + 32'h1;
			case (state_reg)
				param_page_pkg::ST_IDLE: begin
					if (pend_reg && !buf_out_valid) begin
						state_reg    <= param_page_pkg::ST_WALK;
						mode_reg     <= pend_mode_reg;
						walk_cnt_reg <= 9'h0;
						cyc_cnt_reg  <= 32'h0;
					end
				end
				param_page_pkg::ST_WALK: begin
					walk_cnt_reg <= walk_cnt_reg + 9'h1;
					if (walk_cnt_reg == param_page_pkg::PAGE_WORDS) begin
						state_reg <= (mode_reg == param_page_pkg::MODE_SCRUB)
							? param_page_pkg::ST_IDLE : param_page_pkg::ST_WAIT;
					end
				end
				param_page_pkg::ST_WAIT: begin
					if (cyc_cnt_reg >= cyc_target - 32'h1) begin
						state_reg <= param_page_pkg::ST_IDLE;
					end
				end
				default: begin
					state_reg <= param_page_pkg::ST_IDLE;
				end
			endcase
		end
	end
	assign write_in_progress = busy;

	// Program clears only bits written low; erase forces ones
	always_comb begin
		page_wdata = page_q & stage_q;
		if (mode_reg == param_page_pkg::MODE_ERASE) begin
			page_wdata = param_page_pkg::ERASED_BYTE;
		end
	end
	assign page_we  = walking & (walk_cnt_reg != 9'h0) & (mode_reg != param_page_pkg::MODE_SCRUB);
	assign stage_we = walking ? (walk_cnt_reg != 9'h0) : (buf_out_valid & buf_out_ready);

	// Committed parameter page
	page_mem u_page (
		.sys_clk (sys_clk),
		.we      (page_we),
		.waddr   (wr_addr),
		.wdata   (page_wdata),
		.raddr   (walking ? walk_addr : page_rd_addr),
		.rdata   (page_q)
	);

	// Staging copy, left all ones after every walk
	page_mem u_stage (
		.sys_clk (sys_clk),
		.we      (stage_we),
		.waddr   (walking ? wr_addr : buf_head[15:8]),
		.wdata   (walking ? param_page_pkg::ERASED_BYTE : buf_head[7:0]),
		.raddr   (walk_addr),
		.rdata   (stage_q)
	);
	assign page_rd_data = page_q;

	// ****************************************
	// Status read-out
	// ****************************************
	logic [7:0] status;
	logic [2:0] out_idx_reg;
	logic       so_reg, so_oe_reg, rdsr_active;

	assign status = param_page_pkg::STATUS_RESET
		| (8'(busy) << param_page_pkg::ST_WIP_BIT)
		| (8'(wel_reg) << param_page_pkg::ST_WEL_BIT)
		| (8'(block_protect) << param_page_pkg::ST_BP_LSB);
	// Status is served even in a busy cycle, never during lockout
	assign rdsr_active = selected & ready_reg & (byte_cnt_reg != 3'h0)
		& (opcode_reg == param_page_pkg::OP_READ_STATUS);

	// Shift out MSB first on each falling clock, repeating
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			out_idx_reg <= 3'h0;
			so_reg      <= 1'b0;
			so_oe_reg   <= 1'b0;
		end else begin
			so_oe_reg <= rdsr_active;
			if (!rdsr_active) begin
				out_idx_reg <= 3'h0;
			end else if (sck_fall) begin
				so_reg      <= status[3'h7 - out_idx_reg];
				out_idx_reg <= out_idx_reg + 3'h1;
			end
		end
	end
	assign spi_so    = so_reg;
	assign spi_so_oe = so_oe_reg;

	// ****************************************
	// Assertions
	// ****************************************
	default clocking @(posedge sys_clk); endclocking
	default disable iff (rst);

	wel_clear_a: assert property (
		pend_reg && !$past(pend_reg) && pend_mode_reg != param_page_pkg::MODE_SCRUB
		|-> !wel_reg) else $error("latch kept");
	prot_check_a: assert property (
		$rose(pend_reg) && pend_mode_reg != param_page_pkg::MODE_SCRUB
		|-> $past(block_protect) == 3'h0) else $error("protected start");
	whole_frame_a: assert property (
		$rose(pend_reg) && pend_mode_reg != param_page_pkg::MODE_SCRUB
		|-> $past(bit_cnt_reg) == 3'h0) else $error("partial frame");
	// Every word of an erase walk must really be written, and with ones
	erase_ff_a: assert property (
		walking && mode_reg == param_page_pkg::MODE_ERASE && walk_cnt_reg != 9'h0
		|-> page_we && page_wdata == param_page_pkg::ERASED_BYTE) else $error("erase not ff");
	// Busy may only end after the full count, a scrub walk or a supply loss
	wip_hold_a: assert property (
		$fell(write_in_progress) |-> !$past(ready_reg)
		|| $past(mode_reg) == param_page_pkg::MODE_SCRUB
		|| ($past(state_reg) == param_page_pkg::ST_WAIT
		&& $past(cyc_cnt_reg) >= $past(cyc_target) - 32'h1)) else $error("wip dropped");
	lockout_a: assert property (
		!ready_reg |=> !wel_reg && !pend_reg && !spi_so_oe) else $error("active in lockout");
	supply_a: assert property (
		!supply_s |=> !device_ready) else $error("ready without supply");
	addr_low_a: assert property (
		byte_done && byte_cnt_reg == 3'h3
		|=> addr_reg == $past(rx_byte)) else $error("byte address");
	busy_ign_a: assert property (
		busy && cs_rise && ready_reg
		|=> wel_reg == $past(wel_reg)) else $error("command in cycle");
	erase_len_a: assert property (
		state_reg == param_page_pkg::ST_WAIT && mode_reg == param_page_pkg::MODE_ERASE
		&& cyc_cnt_reg < 32'(ERASE_CYCLES - 1)
		|=> state_reg == param_page_pkg::ST_WAIT) else $error("erase short");

	erase_done_c: cover property (state_reg == param_page_pkg::ST_WAIT && mode_reg == param_page_pkg::MODE_ERASE ##1 state_reg == param_page_pkg::ST_IDLE);
	prog_done_c: cover property (state_reg == param_page_pkg::ST_WAIT && mode_reg == param_page_pkg::MODE_PROG ##1 state_reg == param_page_pkg::ST_IDLE);
	scrub_c: cover property (go_scrub);
	busy_read_c: cover property (busy && so_oe_reg);
endmodule : param_page_engine

/* verilog/param_page_pkg.sv */
// Constants shared by the parameter page engine and its page memory.
// Assumes a single 250 MHz system clock; times are converted to cycles here.
package param_page_pkg;

	// ****************************************
	// Opcodes
	// ****************************************
	localparam logic [7:0] OP_WRITE_ENABLE = 8'h06;
	localparam logic [7:0] OP_READ_STATUS  = 8'h05;
	localparam logic [7:0] OP_PAGE_PROGRAM = 8'h52;
	localparam logic [7:0] OP_PAGE_ERASE   = 8'hd5;

	// ****************************************
	// Status register layout and reset value
	// ****************************************
	localparam int unsigned ST_WIP_BIT   = 0;
	localparam int unsigned ST_WEL_BIT   = 1;
	localparam int unsigned ST_BP_LSB    = 2;
	localparam logic [7:0]  STATUS_RESET = 8'h00;
	localparam logic [7:0]  ERASED_BYTE  = 8'hff;

	// ****************************************
	// Frame geometry
	// ****************************************
	localparam logic [2:0] BYTES_HEADER = 3'h4;  // Opcode plus three address bytes
	localparam logic [2:0] BYTES_SAT    = 3'h5;  // Byte counter saturates here
	localparam logic [8:0] PAGE_WORDS   = 9'h100;

	// ****************************************
	// Timing
	// ****************************************
	localparam int unsigned CLK_MHZ         = 250;
	localparam int unsigned LOCKOUT_MS      = 10;    // Least time
	localparam int unsigned PROGRAM_US      = 1500;  // Typical program time
	localparam int unsigned ERASE_MS        = 20;    // Typical, well under 100 ms
	localparam int unsigned LOCKOUT_CYCLES  = LOCKOUT_MS * 1000 * CLK_MHZ;
	localparam int unsigned PROGRAM_CYCLES  = PROGRAM_US * CLK_MHZ;
	localparam int unsigned ERASE_CYCLES    = ERASE_MS * 1000 * CLK_MHZ;

	// ****************************************
	// Cycle engine states and modes
	// ****************************************
	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_WALK = 2'b01,
		ST_WAIT = 2'b11
	} cycle_state_t;

	typedef enum logic [1:0] {
		MODE_SCRUB = 2'b00,
		MODE_PROG  = 2'b01,
		MODE_ERASE = 2'b10
	} cycle_mode_t;

endpackage : param_page_pkg

/* verilog/page_mem.sv */
// 256 x 8 page store with one write port and one registered read port.
// Assumes the caller never needs write-through on a same-address read.
`timescale 1ns/1ps
module page_mem (
	input  wire logic       sys_clk,
	input  wire logic       we,
	input  wire logic [7:0] waddr,
	input  wire logic [7:0] wdata,
	input  wire logic [7:0] raddr,
	output logic      [7:0] rdata
);
	logic [7:0] mem [0:255];

	// Delivered state: every byte erased
	initial begin
		for (int i = 0; i < 256; i++) begin
			mem[i] = param_page_pkg::ERASED_BYTE;
		end
	end

	// Write port
	always_ff @(posedge sys_clk) begin
		if (we) begin
			mem[waddr] <= wdata;
		end
	end

	// Read data from a flip-flop
	always_ff @(posedge sys_clk) begin
		rdata <= mem[raddr];
	end
endmodule : page_mem

/* bench/spi_host_model.sv */
// SPI host model: drives chip select, serial clock and data in, samples data out.
// Assumes mode 0, MSB first; the 48 ns serial clock runs only inside frames.
`timescale 1ns/1ps
module spi_host_model (
	output logic      spi_cs_n,
	output logic      spi_sck,
	output logic      spi_si,
	input  wire logic spi_so
);
	// ****************************************
	// Idle levels
	// ****************************************
	// Chip select stays high from time zero, so nothing is selected at power-up
	initial begin
		spi_cs_n = 1'b1;
		spi_sck  = 1'b0;
		spi_si   = 1'b0;
	end

	// ****************************************
	// One frame of n bits taken from the top of bits
	// ****************************************
	// Chip select held low through the frame; rx keeps the last eight bits seen on so
	task automatic frame(input logic [63:0] bits, input int n, output logic [7:0] rx);
		rx       = 8'h00;
		spi_cs_n = 1'b0;
		for (int i = 0; i < n; i++) begin
			spi_si = bits[63 - i];
			#24;
			spi_sck = 1'b1;
			rx      = {rx[6:0], spi_so};
			#24;
			spi_sck = 1'b0;
		end
		#24;
		spi_cs_n = 1'b1;
		// A released data line must not keep showing the last bit
		spi_si   = ~spi_si;
		#120;
	endtask : frame
endmodule : spi_host_model

/* bench/tb_top.sv */
// Testbench for the parameter page engine, with an SPI host model on the link.
// Assumes short lockout and cycle counts, set at the instance below.
`timescale 1ns/1ps
module tb_top;
	logic       sys_clk;
	logic       rst;
	logic       spi_cs_n;
	logic       spi_sck;
	logic       spi_si;
	logic       supply_ok;
	logic [2:0] block_protect;
	logic [7:0] page_rd_addr;
	logic [7:0] page_rd_data;
	logic [7:0] rx;
	logic       spi_so;
	logic       spi_so_oe;
	logic       write_in_progress;
	logic       write_enable_latch;
	logic       device_ready;
	int         miscompares = 0;
	int         samples_checked = 0;
	int         oe_seen = 0;

	// ****************************************
	// Design and host
	// ****************************************
	// Lockout longer than one frame, so a frame sent at once falls inside it
	param_page_engine #(.LOCKOUT_CYCLES(300), .PROGRAM_CYCLES(400), .ERASE_CYCLES(400)) dut_u (
		.sys_clk(sys_clk), .rst(rst), .spi_cs_n(spi_cs_n), .spi_sck(spi_sck),
		.spi_si(spi_si), .supply_ok(supply_ok), .block_protect(block_protect),
		.page_rd_addr(page_rd_addr), .page_rd_data(page_rd_data), .spi_so(spi_so),
		.spi_so_oe(spi_so_oe), .write_in_progress(write_in_progress),
		.write_enable_latch(write_enable_latch), .device_ready(device_ready));
	spi_host_model host_u (.spi_cs_n(spi_cs_n), .spi_sck(spi_sck), .spi_si(spi_si),
		.spi_so(spi_so));

	// 250 MHz system clock
	initial begin
		sys_clk = 1'b0;
		forever #2 sys_clk = ~sys_clk;
	end

	// Cycles with data out driven; sampled on the falling edge, clear of its launch
	always @(negedge sys_clk) begin
		if (spi_so_oe === 1'b1) begin
			oe_seen++;
		end
	end

	// ****************************************
	// Shared tasks
	// ****************************************
	task automatic check(input logic [7:0] got, input logic [7:0] exp, input string what);
		samples_checked++;
		if (got !== exp) begin
			miscompares++;
			$display("BAD t=%0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask : check

	task automatic tick(input int n);
		repeat (n) @(posedge sys_clk);
		#1;
	endtask : tick

	task automatic cmd(input logic [63:0] bits, input int n);
		host_u.frame(bits, n, rx);
		tick(1);
	endtask : cmd

	task automatic page(input logic [7:0] a, input logic [7:0] exp, input string what);
		page_rd_addr = a;
		tick(2);
		check(page_rd_data, exp, what);
	endtask : page

	// Bounded wait for the self-timed cycle to end
	task automatic wait_idle();
		for (int i = 0; i < 2000 && write_in_progress !== 1'b0; i++) tick(1);
		check({7'h00, write_in_progress}, 8'h00, "cycle end");
	endtask : wait_idle

	task automatic write_enable_cmd();
		cmd({param_page_pkg::OP_WRITE_ENABLE, 56'h0}, 8);
	endtask : write_enable_cmd

	task automatic status(input logic [7:0] exp);
		int seen;
		seen = oe_seen;
		host_u.frame({param_page_pkg::OP_READ_STATUS, 56'h0}, 16, rx);
		check(rx, exp, "status byte");
		check({7'h00, 1'(oe_seen > seen)}, 8'h01, "output driven in read");
		check({7'h00, spi_so_oe}, 8'h00, "output released after read");
	endtask : status

	// ****************************************
	// Scenarios
	// ****************************************
	task automatic t_powerup();
		check({7'h00, device_ready}, 8'h00, "ready in lockout");
		write_enable_cmd();
		check({7'h00, write_enable_latch}, 8'h00, "latch in lockout");
		check({7'h00, device_ready}, 8'h00, "ready before lockout end");
		for (int i = 0; i < 400 && device_ready !== 1'b1; i++) tick(1);
		check({7'h00, device_ready}, 8'h01, "ready after lockout");
		check({6'h00, write_in_progress, write_enable_latch}, 8'h00, "power-up flags");
		page(8'h37, param_page_pkg::ERASED_BYTE, "delivered byte");
		status(param_page_pkg::STATUS_RESET);
		$display("test powerup done");
	endtask : t_powerup

	task automatic t_program();
		page(8'hfe, param_page_pkg::ERASED_BYTE, "erased before program");
		write_enable_cmd();
		cmd({param_page_pkg::OP_PAGE_PROGRAM, 24'h1234fe, 24'ha53c7e, 8'h00}, 56);
		check({6'h00, write_in_progress, write_enable_latch}, 8'h02, "program start");
		wait_idle();
		page(8'hfe, 8'ha5, "first byte");
		page(8'hff, 8'h3c, "page end");
		page(8'h00, 8'h7e, "wrapped byte");
		page(8'h01, 8'hff, "untouched byte");
		$display("test program done");
	endtask : t_program

	task automatic t_refused();
		cmd({param_page_pkg::OP_PAGE_PROGRAM, 24'h000002, 8'h00, 24'h0}, 40);
		page(8'h02, 8'hff, "program without latch");
		write_enable_cmd();
		block_protect = 3'h4;
		cmd({param_page_pkg::OP_PAGE_PROGRAM, 24'h000003, 8'h00, 24'h0}, 40);
		page(8'h03, 8'hff, "protected program");
		block_protect = 3'h0;
		cmd({param_page_pkg::OP_PAGE_PROGRAM, 24'h000004, 8'h00, 24'h0}, 44);
		wait_idle();
		page(8'h04, 8'hff, "partial byte program");
		$display("test refused done");
	endtask : t_refused

	task automatic t_erase();
		// The latch is still set from the refused frames, so the unlatched case runs last
		write_enable_cmd();
		block_protect = 3'h1;
		cmd({param_page_pkg::OP_PAGE_ERASE, 56'h0}, 8);
		check({7'h00, write_in_progress}, 8'h00, "protected erase");
		block_protect = 3'h0;
		cmd({param_page_pkg::OP_PAGE_ERASE, 56'h0}, 9);
		check({7'h00, write_in_progress}, 8'h00, "nine bit erase");
		cmd({param_page_pkg::OP_PAGE_ERASE, 56'h0}, 8);
		check({6'h00, write_in_progress, write_enable_latch}, 8'h02, "erase start");
		status(8'h01);
		write_enable_cmd();
		wait_idle();
		check({7'h00, write_enable_latch}, 8'h00, "write enable while busy");
		page(8'hfe, 8'hff, "erased byte");
		page(8'h00, 8'hff, "erased byte");
		cmd({param_page_pkg::OP_PAGE_ERASE, 56'h0}, 8);
		check({7'h00, write_in_progress}, 8'h00, "erase without latch");
		$display("test erase done");
	endtask : t_erase

	task automatic t_supply_loss();
		write_enable_cmd();
		check({7'h00, write_enable_latch}, 8'h01, "latch before loss");
		supply_ok = 1'b0;
		tick(6);
		check({7'h00, device_ready}, 8'h00, "ready after loss");
		check({7'h00, write_enable_latch}, 8'h00, "latch cleared by loss");
		write_enable_cmd();
		check({7'h00, write_enable_latch}, 8'h00, "latch after loss");
		$display("test supply_loss done");
	endtask : t_supply_loss

	// ****************************************
	// Run control
	// ****************************************
	task automatic final_report();
		$display("compares %0d mismatches %0d", samples_checked, miscompares);
		if (miscompares == 0 && samples_checked > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask : final_report

	// Watchdog: the whole run takes some tens of microseconds
	initial begin
		#200us;
		miscompares++;
		$display("BAD t=%0t watchdog expired", $time);
		final_report();
	end

	// Main sequence
	initial begin
		rst           = 1'b1;
		supply_ok     = 1'b1;
		block_protect = 3'h0;
		page_rd_addr  = 8'h00;
		tick(6);
		rst = 1'b0;
		t_powerup();
		t_program();
		t_refused();
		t_erase();
		t_supply_loss();
		final_report();
	end
endmodule : tb_top
